// File: design/dmr_consts.svh
// constants for the dual mode register access port
// Operation
// - mode pin low two-wire, high four-wire
// - two-wire slave sends one by releasing data
// - bus identifier depends on chip select level
// - identifier bit zero gives transfer direction
// - eight identifier bits shifted in, msb first
// - matching identifier is acknowledged low
// - mismatch makes device idle until next start
// - complete sequence returns device to idle
// - data change during clock high abandons transfer
// - two-wire uses separate 16-bit register address
// - multiple transfers only with auto-increment enabled
// - auto-increment is control bit 2, resets one
// - four-wire word: direction, 15 address, 16 data
// - four-wire input captured on rising clock
// - chip select rise latches last 32 bits
// - four-wire read ignores input, data on output
// - serial output open drain, released when idle
// - every register readable through the port
`ifndef DMR_CONSTS_SVH
`define DMR_CONSTS_SVH
`define DMR_CTRL_ADDR     16'h4007
`define DMR_CTRL_RESET    16'h0004
`define DMR_ADDRESS_STEP_ENABLE_BIT   2
`define DMR_ID_CS_LOW     7'h34
`define DMR_ID_CS_HIGH    7'h36
`define DMR_SPI_ADDR_BITS 15
`define DMR_SPI_DATA_BITS 16
`define DMR_SPI_WORD_BITS 32
`define DMR_SPI_CNT_FULL  6'd32
`define DMR_SPI_CNT_ADDR  6'd15
`define DMR_SPI_CNT_DATA  6'd16
`define DMR_BYTE_BITS     4'd8
`define DMR_SYNC_RESET    5'b00111
`endif

// File: design/dmr_pkg.sv
// types for the dual mode register access port
package dmr_pkg;
    typedef enum logic [2:0] {
        DMR_IDLE = 3'b000,
        DMR_RX   = 3'b001,
        DMR_ACK  = 3'b010,
        DMR_TX   = 3'b011,
        DMR_MACK = 3'b100
    } dmr_i2c_e;
endpackage

// File: design/dmr_port.sv
// serial register access port, two-wire or four-wire
`timescale 1ns/1ns
`include "dmr_consts.svh"
module dmr_port (
    // core clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // link pins
    input  wire logic        serial_clock_in,
    input  wire logic        port_protocol_select_pin,
    input  wire logic        chip_select_n,
    input  wire logic        serial_data_io_in,
    output logic             serial_data_io_out,
    output logic             serial_data_io_oe_n,
    output logic             serial_data_out,
    output logic             serial_data_out_oe_n,
    // register side
    output logic [15:0]      reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata,
    output logic             address_step_enable
);
    import dmr_pkg::*;

    // link clock domain state
    logic [31:0] spi_rx;
    logic        spi_tgl;
    logic [5:0]  spi_cnt;
    logic        spi_rw;
    logic        spi_sdo_oe_n;
    logic        spi_frame_rst;
    logic [31:0] next_spi_rx;
    logic        next_spi_tgl;
    logic [5:0]  next_spi_cnt;
    logic        next_spi_rw;
    logic        next_spi_sdo_oe_n;
    // core domain state
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  flt;
    logic [4:0]  flt_d;
    logic [4:0]  next_flt;
    dmr_i2c_e    state;
    dmr_i2c_e    next_state;
    logic [3:0]  bitcnt;
    logic [3:0]  next_bitcnt;
    logic [1:0]  bytecnt;
    logic [1:0]  next_bytecnt;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic [7:0]  wd_hi;
    logic [7:0]  next_wd_hi;
    logic [15:0] tx;
    logic [15:0] next_tx;
    logic [15:0] addr;
    logic [15:0] next_addr;
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [15:0] wdata;
    logic [15:0] next_wdata;
    logic [15:0] spi_rdata;
    logic [15:0] next_spi_rdata;
    logic        rw;
    logic        next_rw;
    logic        hi_half;
    logic        next_hi_half;
    logic        last;
    logic        next_last;
    logic        sda_oe_n;
    logic        next_sda_oe_n;
    logic        inc_pend;
    logic        next_inc_pend;
    logic        fetch_pend;
    logic        next_fetch_pend;
    logic        wr_p;
    logic        next_wr_p;
    logic        rd_p;
    logic        next_rd_p;

    // read mux: the control register answers here, all others from outside
    function automatic logic [15:0] rd_mux(input logic [15:0] a, input logic [15:0] c, input logic [15:0] ext);
        rd_mux = (a == `DMR_CTRL_ADDR) ? c : ext;
    endfunction

    // frame state of the four-wire shifter clears whenever chip select is high
    assign spi_frame_rst = chip_select_n | ~rst_n;

    // four-wire input shifter on the link clock
    always_comb begin
        next_spi_rx  = {spi_rx[30:0], serial_data_io_in};
        next_spi_cnt = (spi_cnt == `DMR_SPI_CNT_FULL) ? spi_cnt : spi_cnt + 6'd1;
        next_spi_rw  = (spi_cnt == 6'd0) ? serial_data_io_in : spi_rw;
        next_spi_tgl = spi_tgl ^ ((spi_cnt == `DMR_SPI_CNT_ADDR) & spi_rw);
    end

    // link shift register and request toggle keep their value across frames
    always_ff @(posedge serial_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            spi_rx  <= 32'h0000_0000;
            spi_tgl <= 1'b0;
        end else begin
            spi_rx  <= next_spi_rx;
            spi_tgl <= next_spi_tgl;
        end
    end

    // bit counter and direction restart with each frame
    always_ff @(posedge serial_clock_in or posedge spi_frame_rst) begin
        if (spi_frame_rst) begin
            spi_cnt <= 6'd0;
            spi_rw  <= 1'b0;
        end else begin
            spi_cnt <= next_spi_cnt;
            spi_rw  <= next_spi_rw;
        end
    end

    // read data out msb first, only zeros are driven
    always_comb begin
        next_spi_sdo_oe_n = 1'b1;
        if (port_protocol_select_pin && spi_rw && spi_cnt >= `DMR_SPI_CNT_DATA && spi_cnt < `DMR_SPI_CNT_FULL) begin
            next_spi_sdo_oe_n = spi_rdata[~spi_cnt[3:0]];
        end
    end

    // output changes after falling link clock edges
    always_ff @(negedge serial_clock_in or posedge spi_frame_rst) begin
        if (spi_frame_rst) begin
            spi_sdo_oe_n <= 1'b1;
        end else begin
            spi_sdo_oe_n <= next_spi_sdo_oe_n;
        end
    end

    // pin and toggle filter: a change counts once stages two and three agree
    always_comb begin
        next_flt = flt;
        for (int i = 0; i < 5; i++) begin
            if (s2[i] == s3[i]) begin
                next_flt[i] = s3[i];
            end
        end
    end

    // three-stage synchronisers: bit 0 data, 1 clock, 2 select, 3 mode, 4 toggle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= `DMR_SYNC_RESET;
            s2    <= `DMR_SYNC_RESET;
            s3    <= `DMR_SYNC_RESET;
            flt   <= `DMR_SYNC_RESET;
            flt_d <= `DMR_SYNC_RESET;
        end else begin
            s1    <= {spi_tgl, port_protocol_select_pin, chip_select_n, serial_clock_in, serial_data_io_in};
            s2    <= s1;
            s3    <= s2;
            flt   <= next_flt;
            flt_d <= flt;
        end
    end

    // protocol engine and register access
    always_comb begin
        logic        i2c_mode;
        logic        sda;
        logic        rise;
        logic        fall;
        logic [15:0] wd;
        i2c_mode        = ~flt[3];
        sda             = flt[0];
        rise            = flt[1] & ~flt_d[1];
        fall            = ~flt[1] & flt_d[1];
        wd              = {wd_hi, shift};
        next_state      = state;
        next_bitcnt     = bitcnt;
        next_bytecnt    = bytecnt;
        next_shift      = shift;
        next_wd_hi      = wd_hi;
        next_tx         = tx;
        next_addr       = addr;
        next_ctrl       = ctrl;
        next_wdata      = wdata;
        next_spi_rdata  = spi_rdata;
        next_rw         = rw;
        next_hi_half    = hi_half;
        next_last       = last;
        next_sda_oe_n   = sda_oe_n;
        next_inc_pend   = 1'b0;
        next_fetch_pend = 1'b0;
        next_wr_p       = 1'b0;
        next_rd_p       = 1'b0;
        // deferred address step, then optional fetch at the new address
        if (inc_pend) begin
            next_addr       = addr + 16'h0001;
            next_fetch_pend = rw;
        end
        if (fetch_pend) begin
            next_rd_p = 1'b1;
            if (i2c_mode) begin
                next_tx = rd_mux(addr, ctrl, reg_rdata);
            end else begin
                next_spi_rdata = rd_mux(addr, ctrl, reg_rdata);
            end
        end
        if (!i2c_mode) begin
            next_state    = DMR_IDLE;
            next_sda_oe_n = 1'b1;
            // four-wire read request: address held until the frame goes on
            if (flt[4] != flt_d[4]) begin
                next_addr       = {1'b0, spi_rx[`DMR_SPI_ADDR_BITS-1:0]};
                next_fetch_pend = 1'b1;
            end
            // frame end: a write word is taken from the last 32 bits
            if (flt[2] && !flt_d[2] && !spi_rx[`DMR_SPI_WORD_BITS-1]) begin
                next_addr = {1'b0, spi_rx[`DMR_SPI_WORD_BITS-2:`DMR_SPI_DATA_BITS]};
                if (next_addr == `DMR_CTRL_ADDR) begin
                    next_ctrl = spi_rx[15:0] & `DMR_CTRL_RESET;
                end else begin
                    next_wdata = spi_rx[15:0];
                    next_wr_p  = 1'b1;
                end
            end
        end else if (flt[1] && flt_d[1] && flt[0] != flt_d[0]) begin
            // data moved while the clock was high: start or stop
            next_sda_oe_n = 1'b1;
            next_state    = sda ? DMR_IDLE : DMR_RX;
            next_bitcnt   = 4'd0;
            next_bytecnt  = 2'd0;
        end else begin
            unique case (state)
                DMR_IDLE: begin
                    next_sda_oe_n = 1'b1;
                end
                DMR_RX: begin
                    if (rise) begin
                        next_shift  = {shift[6:0], sda};
                        next_bitcnt = bitcnt + 4'd1;
                    end else if (fall && bitcnt == `DMR_BYTE_BITS) begin
                        next_state    = DMR_ACK;
                        next_sda_oe_n = 1'b0;
                        next_last     = 1'b0;
                        unique case (bytecnt)
                            2'd0: begin
                                next_rw         = shift[0];
                                next_bytecnt    = 2'd1;
                                next_hi_half    = 1'b1;
                                next_fetch_pend = shift[0];
                                if (shift[7:1] != (flt[2] ? `DMR_ID_CS_HIGH : `DMR_ID_CS_LOW)) begin
                                    next_state      = DMR_IDLE;
                                    next_sda_oe_n   = 1'b1;
                                    next_fetch_pend = 1'b0;
                                end
                            end
                            2'd1: begin
                                next_addr[15:8] = shift;
                                next_bytecnt    = 2'd2;
                            end
                            2'd2: begin
                                next_addr[7:0] = shift;
                                next_bytecnt   = 2'd3;
                                next_hi_half   = 1'b1;
                            end
                            2'd3: begin
                                next_hi_half = ~hi_half;
                                if (hi_half) begin
                                    next_wd_hi = shift;
                                end else begin
                                    next_inc_pend = ctrl[`DMR_ADDRESS_STEP_ENABLE_BIT];
                                    next_last     = ~ctrl[`DMR_ADDRESS_STEP_ENABLE_BIT];
                                    if (addr == `DMR_CTRL_ADDR) begin
                                        next_ctrl = wd & `DMR_CTRL_RESET;
                                    end else begin
                                        next_wdata = wd;
                                        next_wr_p  = 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
                DMR_ACK: begin
                    if (fall) begin
                        next_bitcnt = 4'd0;
                        if (last) begin
                            next_state    = DMR_IDLE;
                            next_sda_oe_n = 1'b1;
                        end else if (rw) begin
                            next_state    = DMR_TX;
                            next_sda_oe_n = tx[15];
                            next_tx       = {tx[14:0], tx[15]};
                            next_bitcnt   = 4'd1;
                        end else begin
                            next_state    = DMR_RX;
                            next_sda_oe_n = 1'b1;
                        end
                    end
                end
                DMR_TX: begin
                    if (fall) begin
                        if (bitcnt == `DMR_BYTE_BITS) begin
                            next_state    = DMR_MACK;
                            next_sda_oe_n = 1'b1;
                        end else begin
                            next_sda_oe_n = tx[15];
                            next_tx       = {tx[14:0], tx[15]};
                            next_bitcnt   = bitcnt + 4'd1;
                        end
                    end
                end
                DMR_MACK: begin
                    if (rise) begin
                        if (sda || (!hi_half && !ctrl[`DMR_ADDRESS_STEP_ENABLE_BIT])) begin
                            next_state = DMR_IDLE;
                        end else if (!hi_half) begin
                            next_inc_pend = 1'b1;
                        end
                    end else if (fall) begin
                        next_state    = DMR_TX;
                        next_hi_half  = ~hi_half;
                        next_sda_oe_n = tx[15];
                        next_tx       = {tx[14:0], tx[15]};
                        next_bitcnt   = 4'd1;
                    end
                end
                default: begin
                    next_state    = DMR_IDLE;
                    next_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // engine registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= DMR_IDLE;
            bitcnt     <= 4'd0;
            bytecnt    <= 2'd0;
            shift      <= 8'h00;
            wd_hi      <= 8'h00;
            tx         <= 16'h0000;
            addr       <= 16'h0000;
            ctrl       <= `DMR_CTRL_RESET;
            wdata      <= 16'h0000;
            spi_rdata  <= 16'h0000;
            rw         <= 1'b0;
            hi_half    <= 1'b1;
            last       <= 1'b0;
            sda_oe_n   <= 1'b1;
            inc_pend   <= 1'b0;
            fetch_pend <= 1'b0;
            wr_p       <= 1'b0;
            rd_p       <= 1'b0;
        end else begin
            state      <= next_state;
            bitcnt     <= next_bitcnt;
            bytecnt    <= next_bytecnt;
            shift      <= next_shift;
            wd_hi      <= next_wd_hi;
            tx         <= next_tx;
            addr       <= next_addr;
            ctrl       <= next_ctrl;
            wdata      <= next_wdata;
            spi_rdata  <= next_spi_rdata;
            rw         <= next_rw;
            hi_half    <= next_hi_half;
            last       <= next_last;
            sda_oe_n   <= next_sda_oe_n;
            inc_pend   <= next_inc_pend;
            fetch_pend <= next_fetch_pend;
            wr_p       <= next_wr_p;
            rd_p       <= next_rd_p;
        end
    end

    // outputs: open-drain pins only ever pull low
    assign serial_data_io_out   = 1'b0;
    assign serial_data_io_oe_n  = sda_oe_n;
    assign serial_data_out      = 1'b0;
    assign serial_data_out_oe_n = spi_sdo_oe_n;
    assign reg_addr             = addr;
    assign reg_wdata            = wdata;
    assign reg_wr               = wr_p;
    assign reg_rd               = rd_p;
    assign address_step_enable  = ctrl[`DMR_ADDRESS_STEP_ENABLE_BIT];
endmodule // dmr_port

// File: bench/dmr_port_sva.sv
// assertion checker for the serial register access port
`timescale 1ns/1ns
module dmr_port_sva (
    // core clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // link pins
    input wire logic        serial_clock_in,
    input wire logic        port_protocol_select_pin,
    input wire logic        chip_select_n,
    input wire logic        serial_data_io_in,
    input wire logic        serial_data_io_out,
    input wire logic        serial_data_io_oe_n,
    input wire logic        serial_data_out,
    input wire logic        serial_data_out_oe_n,
    // register side
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        address_step_enable
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // open drain pins only ever pull low
    a_sda_pull_low: assert property (!serial_data_io_oe_n |-> !serial_data_io_out)
        else $error("data line driven high");
    a_sdo_pull_low: assert property (!serial_data_out_oe_n |-> !serial_data_out)
        else $error("data output driven high");
    // mode pin and frame gate the two pins
    a_fourwire_quiet: assert property (port_protocol_select_pin [*6] |-> serial_data_io_oe_n)
        else $error("data line driven in four-wire mode");
    a_sdo_in_frame: assert property ($fell(serial_data_out_oe_n) |-> !chip_select_n && port_protocol_select_pin)
        else $error("data output driven outside a frame");
    // pin changes land while the serial clock is low
    a_sdo_on_fall: assert property ($changed(serial_data_out_oe_n) |-> !serial_clock_in || chip_select_n)
        else $error("data output changed with clock high");
    a_ack_clock_low: assert property ($fell(serial_data_io_oe_n) |-> !serial_clock_in)
        else $error("data line pulled with clock high");
    // register side strobes
    a_ctrl_kept_in: assert property (reg_wr |-> reg_addr != 16'h4007)
        else $error("control register write left the block");
    a_wr_one_cycle: assert property (reg_wr |=> !reg_wr && !reg_rd)
        else $error("write strobe too long");
    a_rd_one_cycle: assert property (reg_rd |=> !reg_rd && !reg_wr)
        else $error("read strobe too long");
    a_step_after_wr: assert property (reg_wr && address_step_enable && !port_protocol_select_pin
        |=> reg_addr == $past(reg_addr) + 16'h0001)
        else $error("address did not step after write");
    a_step_reset: assert property ($rose(rst_n) |-> address_step_enable)
        else $error("step enable not set after reset");

    // main scenarios
    c_write: cover property (reg_wr);
    c_read: cover property (reg_rd);
    c_ack: cover property ($fell(serial_data_io_oe_n));
    c_sdo: cover property ($fell(serial_data_out_oe_n));
endmodule // dmr_port_sva

// File: bench/dmr_host.sv
// host serial master model for both link modes
`timescale 1ns/1ns
module dmr_host (
    // pins driven by the host
    output logic      serial_clock_in,
    output logic      chip_select_n,
    output logic      sda_drive,
    // line levels seen by the host
    input  wire logic sda_line,
    input  wire logic sdo_line
);
    localparam int TP = 64;
    int          acks;
    logic        smp;
    logic [7:0]  rb;
    logic [15:0] rq[$];

    // bus idles with the two-wire clock high and the data line released
    initial begin
        serial_clock_in = 1'b1;
        chip_select_n = 1'b0;
        sda_drive = 1'b1;
        acks = 0;
    end

    // one two-wire clock pulse, data set while the clock is low
    task automatic clk2(input logic b);
        #24 sda_drive = b;
        #TP serial_clock_in = 1'b1;
        #(TP/2) smp = sda_line;
        #(TP/2) serial_clock_in = 1'b0;
    endtask

    task automatic start2();
        #24 sda_drive = 1'b1;
        #TP serial_clock_in = 1'b1;
        #TP sda_drive = 1'b0;
        #TP serial_clock_in = 1'b0;
    endtask

    task automatic stop2();
        #24 sda_drive = 1'b0;
        #TP serial_clock_in = 1'b1;
        #TP sda_drive = 1'b1;
        #TP;
    endtask

    task automatic wbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk2(b[i]);
        clk2(1'b1);
        if (smp === 1'b0) acks++;
    endtask

    // register write from address a on, auto-stepping
    task automatic wr2(input logic [7:0] id, input logic [15:0] a, input logic [15:0] d[$]);
        start2();
        wbyte({id[7:1], 1'b0});
        wbyte(a[15:8]);
        wbyte(a[7:0]);
        foreach (d[i]) begin
            wbyte(d[i][15:8]);
            wbyte(d[i][7:0]);
        end
        stop2();
    endtask

    // address phase, repeated start, n registers read, last low byte not acked
    task automatic rd2(input logic [7:0] id, input logic [15:0] a, input int n);
        logic [7:0] hi;
        start2();
        wbyte({id[7:1], 1'b0});
        wbyte(a[15:8]);
        wbyte(a[7:0]);
        start2();
        wbyte({id[7:1], 1'b1});
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                clk2(1'b1);
                rb[i] = smp;
            end
            clk2(1'b0);
            hi = rb;
            for (int i = 7; i >= 0; i--) begin
                clk2(1'b1);
                rb[i] = smp;
            end
            clk2(k == n - 1);
            rq.push_back({hi, rb});
        end
        stop2();
    endtask

    // one four-wire frame, read data sampled before each of the last 16 rising edges
    task automatic frame4(input logic [31:0] w);
        logic [15:0] r;
        serial_clock_in = 1'b0;
        #29 chip_select_n = 1'b0;
        for (int i = 0; i < 32; i++) begin
            sda_drive = w[31-i];
            #24;
            if (i >= 16) r[31-i] = sdo_line;
            serial_clock_in = 1'b1;
            #(i == 15 ? 96 : 24);
            serial_clock_in = 1'b0;
        end
        #24 chip_select_n = 1'b1;
        sda_drive = 1'b1;
        if (w[31]) rq.push_back(r);
        #64;
    endtask
endmodule // dmr_host

// File: bench/tb_dual_mode_register_access_port.sv
// testbench for the dual mode register access port
`timescale 1ns/1ns
`include "dmr_consts.svh"
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
end
module tb_dual_mode_register_access_port;
    import dmr_pkg::*;
    logic        core_clk, rst_n, mode;
    logic        sck, cs_n, h_sda;
    wire         sda, sdo;
    logic        sda_o, sda_oe_n, sdo_o, sdo_oe_n, wr, rd, step;
    logic [15:0] addr, wdata, rdata, base, d;
    logic [15:0] mem [0:255];
    int          model [0:255];
    int          miscompares, check_count, cycles;
    logic [31:0] seed;

    // open drain lines with pull-ups
    assign sda = h_sda & (sda_oe_n ? 1'b1 : sda_o);
    assign sdo = sdo_oe_n ? 1'b1 : sdo_o;
    assign rdata = mem[addr[7:0]];

    dmr_port dut (.core_clk(core_clk), .rst_n(rst_n), .serial_clock_in(sck),
        .port_protocol_select_pin(mode), .chip_select_n(cs_n), .serial_data_io_in(sda),
        .serial_data_io_out(sda_o), .serial_data_io_oe_n(sda_oe_n), .serial_data_out(sdo_o),
        .serial_data_out_oe_n(sdo_oe_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .address_step_enable(step));
    dmr_host host (.serial_clock_in(sck), .chip_select_n(cs_n), .sda_drive(h_sda),
        .sda_line(sda), .sdo_line(sdo));

    // far register file and hang guard
    always @(posedge core_clk) begin
        if (wr) mem[addr[7:0]] <= wdata;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // two-wire write of n random registers, then compare acks and file
    task automatic wr_chk(input logic [7:0] id, input int n, input int acks, input int kept);
        logic [15:0] q[$];
        base = 16'(xs() % 32'd240);
        for (int i = 0; i < n; i++) q.push_back(16'(xs()));
        for (int i = 0; i < kept; i++) model[base + i] = q[i];
        host.acks = 0;
        @(negedge core_clk);
        host.wr2(id, base, q);
        repeat (8) @(negedge core_clk);
        `CHK(host.acks, acks)
        for (int i = 0; i < n; i++) `CHK(mem[base + i], 16'(model[base + i]))
    endtask

    task automatic rd_chk(input logic [7:0] id, input int n);
        host.rq.delete();
        @(negedge core_clk);
        host.rd2(id, base, n);
        for (int i = 0; i < n; i++) `CHK(host.rq[i], 16'(model[base + i]))
    endtask

    task automatic wctl(input logic [15:0] v);
        logic [15:0] q[$];
        q.push_back(v);
        @(negedge core_clk);
        host.wr2(8'h68, `DMR_CTRL_ADDR, q);
        host.rd2(8'h68, `DMR_CTRL_ADDR, 1);
        `CHK(host.rq[$], v)
        `CHK(step, v[`DMR_ADDRESS_STEP_ENABLE_BIT])
    endtask

    initial begin
        seed = 32'h42dc6efd;
        rst_n = 1'b0;
        mode = 1'b0;
        cycles = 0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
            model[i] = 0;
        end
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK(step, 1'b1)
        `CHK({sda_oe_n, sdo_oe_n}, 2'b11)
        repeat (4) @(negedge core_clk);
        // select low: multiple write and read back
        wr_chk(8'h68, 3, 9, 3);
        rd_chk(8'h68, 3);
        // select high picks the other identifier
        host.chip_select_n = 1'b1;
        wr_chk(8'h6c, 1, 5, 1);
        rd_chk(8'h6c, 1);
        wr_chk(8'h68, 1, 0, 0);
        host.chip_select_n = 1'b0;
        // stepping off: only one register per transfer
        wctl(16'h0000);
        wr_chk(8'h68, 2, 5, 1);
        wctl(`DMR_CTRL_RESET);
        // stop inside the low data byte writes nothing
        @(negedge core_clk);
        host.start2();
        host.wbyte(8'h68);
        host.wbyte(8'h00);
        host.wbyte(base[7:0]);
        host.wbyte(8'h5a);
        repeat (3) host.clk2(1'b0);
        host.stop2();
        `CHK(mem[base[7:0]], 16'(model[base]))
        wr_chk(8'h68, 1, 5, 1);
        // four-wire frames, select idles high between them
        host.chip_select_n = 1'b1;
        mode = 1'b1;
        repeat (10) @(negedge core_clk);
        for (int k = 0; k < 4; k++) begin
            base = 16'(xs() % 32'd256);
            d = 16'(xs());
            model[base] = d;
            @(negedge core_clk);
            host.frame4({1'b0, base[14:0], d});
            `CHK(mem[base[7:0]], d)
            @(negedge core_clk);
            host.frame4({1'b1, base[14:0], 16'(xs())});
            `CHK(host.rq[$], d)
        end
        @(negedge core_clk);
        host.frame4({1'b1, 15'h4007, 16'hffff});
        `CHK(host.rq[$], `DMR_CTRL_RESET)
        report_and_stop();
    end
endmodule // tb_dual_mode_register_access_port

bind dmr_port dmr_port_sva chk (.core_clk(core_clk), .rst_n(rst_n), .serial_clock_in(serial_clock_in),
    .port_protocol_select_pin(port_protocol_select_pin), .chip_select_n(chip_select_n),
    .serial_data_io_in(serial_data_io_in), .serial_data_io_out(serial_data_io_out),
    .serial_data_io_oe_n(serial_data_io_oe_n), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .address_step_enable(address_step_enable));
